// *** verilog/spi_slave_pkg.sv ***
/*
 * Constants shared by the serial register access slave and its pin front end.
 * Assumes nothing of its surroundings.
 */
package spi_slave_pkg;

    // ------------------------------------------------------------------
    // Datagram layout
    // ------------------------------------------------------------------
    localparam int unsigned DGRAM_BITS  = 40;
    localparam int unsigned DATA_BITS   = 32;
    localparam int unsigned ADDR_BITS   = 7;
    localparam int unsigned STATUS_BITS = 8;
    localparam int unsigned WR_FLAG_POS = 39;
    localparam int unsigned ADDR_MSB    = 38;
    localparam int unsigned ADDR_LSB    = 32;
    localparam int unsigned CNT_BITS    = 6;

    // ------------------------------------------------------------------
    // Reset values and full datagram count
    // ------------------------------------------------------------------
    localparam logic [DGRAM_BITS-1:0] SHIFT_RESET  = 40'h00_0000_0000;
    localparam logic [DATA_BITS-1:0]  RETURN_RESET = 32'h0000_0000;
    localparam logic [CNT_BITS-1:0]   CNT_RESET    = 6'h00;
    localparam logic [CNT_BITS-1:0]   CNT_FULL     = 6'h28;
    localparam logic [1:0]            SYNC_RESET   = 2'h0;
    localparam logic [1:0]            SYNC_SET     = 2'h3;

    // ------------------------------------------------------------------
    // Link states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } link_state_t;

endpackage : spi_slave_pkg

// *** verilog/link_events_if.sv ***
/*
 * Synchronised link levels and edge events passed from the pin front end
 * to the datagram engine. Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps

interface link_events_if;
    logic selected;
    logic select_fall;
    logic select_rise;
    logic clock_rise;
    logic clock_fall;
    logic data_in;

    modport front (
        output selected,
        output select_fall,
        output select_rise,
        output clock_rise,
        output clock_fall,
        output data_in
    );

    modport engine (
        input selected,
        input select_fall,
        input select_rise,
        input clock_rise,
        input clock_fall,
        input data_in
    );
endinterface : link_events_if

// *** verilog/link_pin_sync.sv ***
/*
 * Two-stage synchronisers for the host select, clock and data pins, plus
 * edge detection on the synchronised select and clock.
 * Assumes the host clock runs at no more than a quarter of clk.
 */
`timescale 1ns/1ps

module link_pin_sync
    import spi_slave_pkg::*;
(
    // System
    input  wire logic   clk,
    input  wire logic   resetn,
    // Pins
    input  wire logic   host_select_n,
    input  wire logic   host_serial_clock,
    input  wire logic   host_serial_in,
    // Events
    link_events_if.front ev
);

    // ------------------------------------------------------------------
    // Synchronisers: stage 1 feeds stage 2 only
    // ------------------------------------------------------------------
    logic [1:0] cs_sync_q,  cs_sync_d;
    logic [1:0] sck_sync_q, sck_sync_d;
    logic [1:0] sdi_sync_q, sdi_sync_d;
    logic       cs_last_q,  cs_last_d;
    logic       sck_last_q, sck_last_d;

    always_comb begin
        cs_sync_d  = {cs_sync_q[0], host_select_n};
        sck_sync_d = {sck_sync_q[0], host_serial_clock};
        sdi_sync_d = {sdi_sync_q[0], host_serial_in};
        cs_last_d  = cs_sync_q[1];
        sck_last_d = sck_sync_q[1];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cs_sync_q  <= SYNC_SET;
            sck_sync_q <= SYNC_RESET;
            sdi_sync_q <= SYNC_RESET;
            cs_last_q  <= 1'b1;
            sck_last_q <= 1'b0;
        end else begin
            cs_sync_q  <= cs_sync_d;
            sck_sync_q <= sck_sync_d;
            sdi_sync_q <= sdi_sync_d;
            cs_last_q  <= cs_last_d;
            sck_last_q <= sck_last_d;
        end
    end

    // ------------------------------------------------------------------
    // Edge events
    // ------------------------------------------------------------------
    assign ev.selected    = ~cs_sync_q[1];
    assign ev.select_fall = cs_last_q & ~cs_sync_q[1];
    assign ev.select_rise = ~cs_last_q & cs_sync_q[1];
    assign ev.clock_rise  = ~sck_last_q & sck_sync_q[1];
    assign ev.clock_fall  = sck_last_q & ~sck_sync_q[1];
    assign ev.data_in     = sdi_sync_q[1];

endmodule : link_pin_sync

// *** verilog/spi_register_access_slave.sv ***
/*
 * Serial register access slave: exchanges 40-bit datagrams with a host
 * master, returns a status byte and pipelined read or echoed write data,
 * and drives one-cycle register read and write strobes on the user side.
 * Assumes the user side answers a read strobe with data in the same cycle.
 */
// Function
// - A datagram is 40 bits: address byte then a 32-bit data word.
// - Bit 39 is write flag, bits 38..32 the register address.
// - Every transfer first shifts out 8 status bits, then 32 return bits.
// - After a read, return the register captured for that read.
// - After a write, return the data received with that write.
// - Read data is captured when the read datagram completes.
// - A read ignores its data bits and writes no register.
// - Register data is right-aligned in the 32-bit field.
// - Select falling edge starts a transfer.
// - Input sampled on clock rise, output updated after clock fall.
// - Datagrams move most significant bit first, from bit 39.
// - Fewer than 40 clocks make the transfer void.
// - Beyond 40 clocks, input bits reach the output 40 clocks later.
// - Select rising edge executes the last 40 bits received.
`timescale 1ns/1ps

module spi_register_access_slave
    import spi_slave_pkg::*;
#(
    parameter int unsigned DW = DATA_BITS,
    parameter int unsigned AW = ADDR_BITS,
    parameter int unsigned SW = STATUS_BITS
) (
    // System
    input  wire logic          clk,
    input  wire logic          resetn,
    // Host link pins
    input  wire logic          host_select_n,
    input  wire logic          host_serial_clock,
    input  wire logic          host_serial_in,
    output logic               host_serial_out,
    // Status events
    input  wire logic [SW-1:0] status_bits,
    // Register access
    output logic               reg_write,
    output logic               reg_read,
    output logic [AW-1:0]      reg_addr,
    output logic [DW-1:0]      reg_wdata,
    input  wire logic [DW-1:0] reg_rdata
);
    import spi_slave_pkg::*;

    link_events_if ev ();

    link_pin_sync u_sync (
        .clk               (clk),
        .resetn            (resetn),
        .host_select_n     (host_select_n),
        .host_serial_clock (host_serial_clock),
        .host_serial_in    (host_serial_in),
        .ev                (ev)
    );

    // ------------------------------------------------------------------
    // Link state
    // ------------------------------------------------------------------
    link_state_t           state_q,   state_d;
    logic [DGRAM_BITS-1:0] shift_q,   shift_d;
    logic [CNT_BITS-1:0]   cnt_q,     cnt_d;
    logic                  sdo_q,     sdo_d;

    // ------------------------------------------------------------------
    // Command and return state
    // ------------------------------------------------------------------
    logic [DW-1:0]         ret_q,     ret_d;
    logic                  wr_q,      wr_d;
    logic                  rd_q,      rd_d;
    logic [AW-1:0]         addr_q,    addr_d;
    logic [DW-1:0]         wdata_q,   wdata_d;

    logic                  done_ok;
    logic                  cmd_write;

    // Whole datagram seen before select released
    assign done_ok   = (state_q == ST_SHIFT) && ev.select_rise
                       && (cnt_q >= CNT_FULL);
    assign cmd_write = shift_q[WR_FLAG_POS];

    // ------------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d   = cnt_q;
        sdo_d   = sdo_q;
        unique case (state_q)
            ST_IDLE: begin
                if (ev.select_fall) begin
                    state_d = ST_SHIFT;
                    shift_d = {status_bits, ret_q};
                    cnt_d   = CNT_RESET;
                    sdo_d   = status_bits[SW-1];
                end
            end
            ST_SHIFT: begin
                if (!ev.selected) begin
                    state_d = ST_IDLE;
                end else if (ev.clock_rise) begin
                    shift_d = {shift_q[DGRAM_BITS-2:0], ev.data_in};
                    if (cnt_q != CNT_FULL) begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end else if (ev.clock_fall) begin
                    sdo_d = shift_q[DGRAM_BITS-1];
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            shift_q <= SHIFT_RESET;
            cnt_q   <= CNT_RESET;
            sdo_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            sdo_q   <= sdo_d;
        end
    end

    // ------------------------------------------------------------------
    // Command execution and return data
    // ------------------------------------------------------------------
    always_comb begin
        ret_d   = ret_q;
        wr_d    = 1'b0;
        rd_d    = 1'b0;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        if (done_ok) begin
            addr_d = shift_q[ADDR_MSB:ADDR_LSB];
            if (cmd_write) begin
                wr_d    = 1'b1;
                wdata_d = shift_q[DW-1:0];
                ret_d   = shift_q[DW-1:0];
            end else begin
                rd_d = 1'b1;
            end
        end
        if (rd_q) begin
            ret_d = reg_rdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ret_q   <= RETURN_RESET;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            addr_q  <= '0;
            wdata_q <= '0;
        end else begin
            ret_q   <= ret_d;
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign host_serial_out = sdo_q;
    assign reg_write       = wr_q;
    assign reg_read        = rd_q;
    assign reg_addr        = addr_q;
    assign reg_wdata       = wdata_q;

endmodule : spi_register_access_slave

// *** tb/spi_slave_checker.sv ***
/* Pin and strobe assertions for the register access slave.
   Assumes it is bound into the slave and sees its ports only. */
`timescale 1ns/1ps
module spi_slave_checker #(
    parameter int unsigned DW = 32,
    parameter int unsigned AW = 7,
    parameter int unsigned SW = 8
) (
    input wire logic          clk,
    input wire logic          resetn,
    input wire logic          host_select_n,
    input wire logic          host_serial_clock,
    input wire logic          host_serial_in,
    input wire logic          host_serial_out,
    input wire logic [SW-1:0] status_bits,
    input wire logic          reg_write,
    input wire logic          reg_read,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata
);
    // ----------------------------------------
    // Shadow of the link as seen at the pins
    // ----------------------------------------
    logic [1:0]  pin_q, pin_d;
    logic [39:0] sh_q, sh_d;
    logic [5:0]  cnt_q, cnt_d;
    logic [2:0]  gap_q, gap_d;
    always_comb begin
        pin_d = {host_select_n, host_serial_clock};
        sh_d  = sh_q;
        cnt_d = host_select_n ? 6'h00 : cnt_q;
        gap_d = (gap_q == 3'h7) ? gap_q : gap_q + 3'h1;
        if (!host_select_n && host_serial_clock && !pin_q[0]) begin
            sh_d  = {sh_q[38:0], host_serial_in};
            cnt_d = (cnt_q == 6'h28) ? cnt_q : cnt_q + 6'h01;
        end
        if ((pin_q[0] && !host_serial_clock) || (pin_q[1] && !host_select_n)) gap_d = 3'h0;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_q <= 2'h2;
            sh_q  <= 40'h00_0000_0000;
            cnt_q <= 6'h00;
            gap_q <= 3'h7;
        end else begin
            pin_q <= pin_d;
            sh_q  <= sh_d;
            cnt_q <= cnt_d;
            gap_q <= gap_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_strobe_alone: assert property (!(reg_write && reg_read))
        else $error("read and write strobes together");
    a_strobe_single: assert property ((reg_write || reg_read) |=> !(reg_write || reg_read))
        else $error("strobe longer than one cycle");
    a_write_fields: assert property (reg_write |-> sh_q[39] && reg_addr == sh_q[38:32]
        && reg_wdata == sh_q[31:0])
        else $error("write strobe does not match datagram");
    a_read_fields: assert property (reg_read |-> !sh_q[39] && reg_addr == sh_q[38:32])
        else $error("read strobe does not match datagram");
    a_short_void: assert property ($rose(host_select_n) && cnt_q != 6'h28
        |-> !(reg_write || reg_read) [*8])
        else $error("short transfer executed");
    a_full_exec: assert property ($rose(host_select_n) && cnt_q == 6'h28
        |-> ##[2:7] (reg_write || reg_read))
        else $error("full transfer not executed");
    a_status_first: assert property ($fell(host_select_n)
        |-> ##6 host_serial_out == status_bits[SW-1])
        else $error("status msb not first out");
    a_out_after_fall: assert property ($changed(host_serial_out) |-> gap_q <= 3'h6)
        else $error("output changed away from a clock fall");
endmodule : spi_slave_checker
bind spi_register_access_slave spi_slave_checker #(.DW(DW), .AW(AW), .SW(SW)) chk (
    .clk(clk), .resetn(resetn), .host_select_n(host_select_n),
    .host_serial_clock(host_serial_clock), .host_serial_in(host_serial_in),
    .host_serial_out(host_serial_out), .status_bits(status_bits), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

// *** tb/host_master_model.sv ***
/* Host master stand-in: sends one datagram per call, gathers the reply.
   Assumes its caller waits for each transfer to end. */
`timescale 1ns/1ps
module host_master_model (
    output logic      host_select_n,
    output logic      host_serial_clock,
    output logic      host_serial_in,
    input wire logic  host_serial_out
);
    logic [47:0] rx;
    event        done;
    initial begin
        host_select_n     = 1'b1;
        host_serial_clock = 1'b0;
        host_serial_in    = 1'b0;
    end
    // Clock n bits of tx out, top bit first; 80 ns clock period
    task automatic xfer(input int n, input logic [47:0] tx);
        rx = 48'h0;
        host_select_n = 1'b0;
        #80;
        for (int i = n - 1; i >= 0; i--) begin
            host_serial_in = tx[i];
            #40 host_serial_clock = 1'b1;
            #39 rx = {rx[46:0], host_serial_out};
            #1 host_serial_clock = 1'b0;
        end
        #80 host_select_n = 1'b1;
        host_serial_in = ~host_serial_in;
        #200 -> done;
    endtask : xfer
endmodule : host_master_model

// *** tb/spi_register_access_slave_test.sv ***
/* Self-checking bench: a host model sends datagrams, a register file
   answers reads. Assumes the slave's default widths. */
`timescale 1ns/1ps
module spi_register_access_slave_test;
    logic        clk, resetn, sel_n, sck, sdi, sdo, reg_write, reg_read;
    logic [7:0]  status_bits;
    logic [6:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, ret, mem [128], ref_mem [128];
    logic [47:0] exp_q [$];
    int          err_total, check_count;
    assign reg_rdata = mem[reg_addr];
    always @(posedge clk) if (reg_write) mem[reg_addr] <= reg_wdata;
    spi_register_access_slave uut (.clk(clk), .resetn(resetn), .host_select_n(sel_n),
        .host_serial_clock(sck), .host_serial_in(sdi), .host_serial_out(sdo),
        .status_bits(status_bits), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    host_master_model m (.host_select_n(sel_n), .host_serial_clock(sck),
        .host_serial_in(sdi), .host_serial_out(sdo));
    // ----------------------------------------
    // Driver, reply watcher and verdict
    // ----------------------------------------
    task automatic chk(input string what, input logic [47:0] e, input logic [47:0] s);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    task automatic send(input int n, input logic [47:0] tx);
        logic [87:0] e;
        @(posedge clk) #2 status_bits = 8'($urandom);
        e = {status_bits, ret, tx} >> (88 - n);
        exp_q.push_back(e[47:0]);
        if (n >= 40 && tx[39]) ret = tx[31:0];
        if (n >= 40 && tx[39]) ref_mem[tx[38:32]] = tx[31:0];
        if (n >= 40 && !tx[39]) ret = ref_mem[tx[38:32]];
        m.xfer(n, tx);
    endtask : send
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    always @(m.done) chk("reply", exp_q.pop_front(), m.rx);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #400us;
        err_total++;
        $display("[ERR] watchdog expected done seen hang");
        results();
    end
    initial begin
        resetn = 1'b0;
        status_bits = 8'h00;
        ret = 32'h0;
        void'($urandom(40155));
        for (int i = 0; i < 128; i++) mem[i] = $urandom;
        ref_mem = mem;
        repeat (12) @(posedge clk);
        #2 resetn = 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 14; i++)
            send(40, {8'h0, 1'($urandom), 7'($urandom_range(3)), 32'($urandom)});
        $display("test pipeline done");
        send(8, 48'h0);
        send(20, 48'h0000_00ab_c123);
        send(40, 48'h00_0200_0000);
        $display("test short done");
        send(48, {8'h5a, 8'h81, 32'($urandom)});
        send(40, 48'h00_0100_0000);
        $display("test daisy done");
        for (int i = 0; i < 128; i++) chk("register", {16'h0, ref_mem[i]}, {16'h0, mem[i]});
        $display("test register file done");
        results();
    end
endmodule : spi_register_access_slave_test
